// >>> logic/gsp_pin_if.sv
// Purpose: Carries the filtered serial pins from the synchronisers to the port logic
// Assumes: All signals on sys_clk
// Notes:   Levels only
`timescale 1ns/1ps
interface gsp_pin_if;
    logic sclk;
    logic ss_n;
    logic mosi;
    logic mode;

    modport src  (output sclk, output ss_n, output mosi, output mode);
    modport sink (input sclk, input ss_n, input mosi, input mode);
endinterface : gsp_pin_if

// >>> logic/gsp_pkg.sv
// Purpose: Shared constants, types and checksum for the rate sensor message port
// Assumes: 48-bit messages, first byte in the most significant bits of a frame
// Notes:   Byte n of a message sits at bits (55-8n) down to (48-8n)
package gsp_pkg;

    // ------------------------------------------------------------------
    // Message layout
    // ------------------------------------------------------------------
    localparam int         MSG_BYTES      = 6;
    localparam int         MSG_BITS       = 48;
    localparam int         CNT_W          = 6;
    localparam logic [5:0] MSG_BITS_C     = 6'h30;
    localparam logic [5:0] CNT_SAT        = 6'h3f;
    localparam int         BYTE1_LSB      = 40;

    // Command byte field positions
    localparam int         CMD_FACTORY    = 7;
    localparam int         CMD_SELF_TEST  = 6;
    localparam int         CMD_RANGE_SRC  = 5;
    localparam int         CMD_RANGE_HI   = 4;
    localparam int         CMD_RANGE_LO   = 3;

    // Status byte field values
    localparam logic [1:0] TYPE_RATE_TEMP = 2'h0;
    localparam logic [2:0] STAT_NORMAL    = 3'h1;

    // ------------------------------------------------------------------
    // Reset values and synchroniser
    // ------------------------------------------------------------------
    localparam logic       RST_SELF_TEST  = 1'b0;
    localparam logic       RST_RANGE_SRC  = 1'b0;
    localparam logic [1:0] RST_RANGE_SEL  = 2'h0;
    localparam logic       RST_PREV_BAD   = 1'b0;
    localparam logic       RST_SCLK       = 1'b0;
    localparam logic       RST_SS_N       = 1'b1;
    localparam logic       RST_MOSI       = 1'b0;
    localparam logic       RST_MODE       = 1'b0;
    localparam int         SYNC_STAGES    = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {GSP_IDLE, GSP_XFER} gsp_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } gsp_sync_state_t;

    typedef struct packed {
        gsp_state_t  st;
        logic        sclk_q;
        logic        ss_q;
        logic [47:0] tx;
        logic [47:0] rx;
        logic [5:0]  cnt;
        logic        self_test;
        logic        range_src;
        logic [1:0]  range_sel;
        logic        prev_bad;
        logic        oe;
        logic        cmd_ok;
        logic        cmd_bad;
    } gsp_port_state_t;

    // Low eight bits of the inverted sum of five bytes
    function automatic logic [7:0] gsp_csum(input logic [39:0] b);
        logic [7:0] s;
        s = b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0];
        return ~s;
    endfunction : gsp_csum

endpackage : gsp_pkg

// >>> logic/gsp_port.sv
// Purpose: Serial message port of a single-axis rate sensor, SPI slave mode 0
// Assumes: Rate, temperature and health come from sensing logic on sys_clk
// Notes:   Serial clock is oversampled by sys_clk; link clock up to 8 MHz
`timescale 1ns/1ps

// Operation
// - Mode select high enables the converter and the serial pin functions.
// - Slave in mode 0: clock idles low, data sampled on rising edge.
// - Every exchange is exactly six bytes, 48 bits, in each direction.
// - Data output is not driven while select is high.
// - Command bit 6 enables the self-test offset; clear disables it.
// - Bit 5 clear uses default range; set lets bits 4 and 3 choose.
// - Command bytes two to five are ignored.
// - Sixth command byte is inverted low byte of sum of bytes one to five.
// - Status bit 7 flags health failure, and is also set during self-test.
// - Status bits 6 and 5 give message type, 00 for rate and temperature.
// - Status bit 4 flags a bad previous command, which was then ignored.
// - Status bit 3 shows whether self-test is enabled.
// - Status bits 2 to 0 read 001 in normal operation.
// - Status bytes two and three carry signed rate, high byte first.
// - Status bytes four and five carry unsigned temperature, high byte first.
module gsp_port (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        mode_sel,
    input  wire logic        spi_sclk,
    input  wire logic        spi_ss_n,
    input  wire logic        spi_mosi,
    output wire logic        spi_miso,
    output wire logic        spi_miso_oe,
    input  wire logic        health_fail,
    input  wire logic [15:0] rate_word,
    input  wire logic [15:0] temp_word,
    output wire logic        adc_enable,
    output wire logic        commanded_self_test,
    output wire logic        range_from_spi,
    output wire logic [1:0]  range_sel,
    output wire logic        prev_cmd_bad,
    output wire logic        cmd_accepted,
    output wire logic        cmd_rejected
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (gsp_pkg::MSG_BITS != 8 * gsp_pkg::MSG_BYTES) begin : g_chk_len
        $error("Message length must be six bytes");
    end
    if (gsp_pkg::SYNC_STAGES != 3) begin : g_chk_sync
        $error("Synchroniser depth is fixed at three");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    gsp_pin_if pin ();

    gsp_sync #(.RST_VAL(gsp_pkg::RST_SCLK)) u_sync_sclk (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .din     (spi_sclk),
        .dout    (pin.sclk)
    );

    gsp_sync #(.RST_VAL(gsp_pkg::RST_SS_N)) u_sync_ss (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .din     (spi_ss_n),
        .dout    (pin.ss_n)
    );

    gsp_sync #(.RST_VAL(gsp_pkg::RST_MOSI)) u_sync_mosi (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .din     (spi_mosi),
        .dout    (pin.mosi)
    );

    gsp_sync #(.RST_VAL(gsp_pkg::RST_MODE)) u_sync_mode (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .din     (mode_sel),
        .dout    (pin.mode)
    );

    // ------------------------------------------------------------------
    // State and edge detection
    // ------------------------------------------------------------------
    gsp_pkg::gsp_port_state_t r;
    gsp_pkg::gsp_port_state_t next_r;

    logic        sclk_rise;
    logic        ss_fall;
    logic        ss_rise;
    logic [7:0]  stat_byte;
    logic [39:0] stat_body;
    logic [47:0] stat_msg;
    logic        csum_ok;
    logic        frame_good;

    assign sclk_rise  = pin.sclk & ~r.sclk_q;
    assign ss_fall    = ~pin.ss_n & r.ss_q;
    assign ss_rise    = pin.ss_n & ~r.ss_q;

    // ------------------------------------------------------------------
    // Status message assembly
    // ------------------------------------------------------------------
    assign stat_byte  = {health_fail | r.self_test,
                         gsp_pkg::TYPE_RATE_TEMP,
                         r.prev_bad,
                         r.self_test,
                         gsp_pkg::STAT_NORMAL};
    assign stat_body  = {stat_byte, rate_word, temp_word};
    assign stat_msg   = {stat_body, gsp_pkg::gsp_csum(stat_body)};

    // Command check over the whole received frame
    assign csum_ok    = (gsp_pkg::gsp_csum(r.rx[47:8]) == r.rx[7:0]);
    assign frame_good = (r.cnt == gsp_pkg::MSG_BITS_C) && csum_ok;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_r         = r;
        next_r.cmd_ok  = 1'b0;
        next_r.cmd_bad = 1'b0;
        next_r.sclk_q  = pin.sclk;
        next_r.ss_q    = pin.ss_n;
        unique case (r.st)
            gsp_pkg::GSP_IDLE: begin
                next_r.oe = 1'b0;
                if (pin.mode && ss_fall) begin
                    next_r.st  = gsp_pkg::GSP_XFER;
                    next_r.tx  = stat_msg;
                    next_r.rx  = '0;
                    next_r.cnt = '0;
                    next_r.oe  = 1'b1;
                end
            end
            gsp_pkg::GSP_XFER: begin
                if (!pin.mode) begin
                    next_r.st = gsp_pkg::GSP_IDLE;
                    next_r.oe = 1'b0;
                end else if (ss_rise) begin
                    next_r.st = gsp_pkg::GSP_IDLE;
                    next_r.oe = 1'b0;
                    if (frame_good) begin
                        // Only byte one is used; bytes two to five are ignored
                        next_r.self_test = r.rx[gsp_pkg::BYTE1_LSB + gsp_pkg::CMD_SELF_TEST];
                        next_r.range_src = r.rx[gsp_pkg::BYTE1_LSB + gsp_pkg::CMD_RANGE_SRC];
                        next_r.range_sel = r.rx[gsp_pkg::BYTE1_LSB + gsp_pkg::CMD_RANGE_HI :
                                                gsp_pkg::BYTE1_LSB + gsp_pkg::CMD_RANGE_LO];
                        next_r.prev_bad  = 1'b0;
                        next_r.cmd_ok    = 1'b1;
                    end else begin
                        next_r.prev_bad  = 1'b1;
                        next_r.cmd_bad   = 1'b1;
                    end
                end else begin
                    if (sclk_rise) begin
                        next_r.rx = {r.rx[46:0], pin.mosi};
                        // Launch the next bit right after the sampling edge so that
                        // the synchroniser delay fits inside one link clock period
                        next_r.tx = {r.tx[46:0], 1'b0};
                        if (r.cnt != gsp_pkg::CNT_SAT) begin
                            next_r.cnt = r.cnt + 6'h01;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r           <= '0;
            r.st        <= gsp_pkg::GSP_IDLE;
            r.ss_q      <= gsp_pkg::RST_SS_N;
            r.sclk_q    <= gsp_pkg::RST_SCLK;
            r.self_test <= gsp_pkg::RST_SELF_TEST;
            r.range_src <= gsp_pkg::RST_RANGE_SRC;
            r.range_sel <= gsp_pkg::RST_RANGE_SEL;
            r.prev_bad  <= gsp_pkg::RST_PREV_BAD;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign spi_miso            = r.tx[47];
    assign spi_miso_oe         = r.oe;
    assign adc_enable          = pin.mode;
    assign commanded_self_test = r.self_test;
    assign range_from_spi      = r.range_src;
    assign range_sel           = r.range_sel;
    assign prev_cmd_bad        = r.prev_bad;
    assign cmd_accepted        = r.cmd_ok;
    assign cmd_rejected        = r.cmd_bad;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic load;
    assign load = (r.st == gsp_pkg::GSP_IDLE) && pin.mode && ss_fall;

    property p_mode_gates_output;
        !pin.mode |=> !spi_miso_oe;
    endproperty
    a_mode_gates_output: assert property (p_mode_gates_output)
        else $error("Output enabled while serial mode is off");

    property p_deselect_float;
        pin.ss_n && !ss_rise |-> !spi_miso_oe;
    endproperty
    a_deselect_float: assert property (p_deselect_float)
        else $error("Data output driven while deselected");

    property p_sample_rise;
        (r.st == gsp_pkg::GSP_XFER) && pin.mode && !ss_rise && sclk_rise
            |=> r.rx[0] == $past(pin.mosi);
    endproperty
    a_sample_rise: assert property (p_sample_rise)
        else $error("Input bit not taken on rising clock");

    property p_shift_rise;
        (r.st == gsp_pkg::GSP_XFER) && pin.mode && !ss_rise && sclk_rise
            |=> r.tx[47] == $past(r.tx[46]);
    endproperty
    a_shift_rise: assert property (p_shift_rise)
        else $error("Output bit not advanced after rising clock");

    property p_status_byte;
        load |=> r.tx[47:40] == {$past(health_fail) | r.self_test, 2'b00,
                                 r.prev_bad, r.self_test, 3'b001};
    endproperty
    a_status_byte: assert property (p_status_byte)
        else $error("Status byte wrong at frame start");

    property p_data_words;
        load |=> r.tx[39:8] == {$past(rate_word), $past(temp_word)};
    endproperty
    a_data_words: assert property (p_data_words)
        else $error("Rate or temperature word misplaced");

    property p_tx_csum;
        load |=> r.tx[7:0] == gsp_pkg::gsp_csum(r.tx[47:8]);
    endproperty
    a_tx_csum: assert property (p_tx_csum)
        else $error("Status checksum wrong");

    property p_good_cmd;
        (r.st == gsp_pkg::GSP_XFER) && pin.mode && ss_rise && frame_good
            |=> cmd_accepted && !prev_cmd_bad
                && commanded_self_test == $past(r.rx[46])
                && range_from_spi == $past(r.rx[45])
                && range_sel == $past(r.rx[44:43]);
    endproperty
    a_good_cmd: assert property (p_good_cmd)
        else $error("Valid command not applied");

    property p_bad_cmd;
        (r.st == gsp_pkg::GSP_XFER) && pin.mode && ss_rise && !frame_good
            |=> cmd_rejected && prev_cmd_bad && $stable(commanded_self_test)
                && $stable(range_sel) && $stable(range_from_spi);
    endproperty
    a_bad_cmd: assert property (p_bad_cmd)
        else $error("Invalid command not ignored or not flagged");

    property p_len_required;
        cmd_accepted |-> $past(r.cnt) == gsp_pkg::MSG_BITS_C;
    endproperty
    a_len_required: assert property (p_len_required)
        else $error("Command accepted with wrong bit count");

    property p_settings_hold;
        !cmd_accepted |-> $stable(commanded_self_test) && $stable(range_sel);
    endproperty
    a_settings_hold: assert property (p_settings_hold)
        else $error("Settings changed without a valid command");

    property p_oe_on_select;
        load |=> spi_miso_oe && (r.st == gsp_pkg::GSP_XFER);
    endproperty
    a_oe_on_select: assert property (p_oe_on_select)
        else $error("Data output not driven once selected");

    property p_one_pulse;
        cmd_accepted || cmd_rejected |=> !cmd_accepted && !cmd_rejected;
    endproperty
    a_one_pulse: assert property (p_one_pulse)
        else $error("Command result pulse longer than one cycle");

    c_good_frame: cover property (cmd_accepted);
    c_bad_frame:  cover property (cmd_rejected);
    c_self_test:  cover property (cmd_accepted && commanded_self_test);
    c_spi_range:  cover property (cmd_accepted && range_from_spi);

endmodule : gsp_port

// >>> logic/gsp_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: din is asynchronous to sys_clk
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ps
module gsp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic din,
    output wire logic dout
);
    gsp_pkg::gsp_sync_state_t r;
    gsp_pkg::gsp_sync_state_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = din;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3) begin
            next_r.q = r.s3;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            r <= next_r;
        end
    end

    assign dout = r.q;
endmodule : gsp_sync

// >>> sim/gsp_host_model.sv
// Purpose: Behavioural host master for the rate sensor message port
// Assumes: Mode 0, link clock half period HALF_NS
// Notes:   Link clock stands low between frames; data line inverts once at each deselect
`timescale 1ns/1ps
module gsp_host_model #(
    parameter int HALF_NS = 24
) (
    output logic      sclk,
    output logic      ss_n,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end

    // ------------------------------------------------------------------
    // One exchange of nbits, first bit first
    // ------------------------------------------------------------------
    task automatic xfer(input logic [47:0] cmd, input int nbits,
                        output logic [47:0] resp, output int oe_hits);
        resp = 48'h0;
        oe_hits = 0;
        ss_n = 1'b0;
        mosi = cmd[47];
        // Give the port time to see select and present its first bit
        #(HALF_NS);
        for (int i = 0; i < nbits; i++) begin
            #(HALF_NS) sclk = 1'b1;
            // A released line reads as the inverse of the port's current data bit
            resp = {resp[46:0], (miso_oe === 1'b1) ? miso : ~miso};
            if (miso_oe === 1'b1) oe_hits++;
            #(HALF_NS) sclk = 1'b0;
            if (i < nbits - 1) mosi = cmd[46 - i];
        end
        #(HALF_NS) ss_n = 1'b1;
        mosi = ~mosi;
    endtask : xfer
endmodule : gsp_host_model

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the rate sensor message port
// Assumes: Host model drives the serial pins, bench drives the rest
// Notes:   Expected status built from tracked settings and live inputs
`timescale 1ns/1ps
module testbench;
    logic        sys_clk;
    logic        rstn;
    logic        mode_sel;
    logic        spi_sclk;
    logic        spi_ss_n;
    logic        spi_mosi;
    logic        spi_miso;
    logic        spi_miso_oe;
    logic        health_fail;
    logic [15:0] rate_word;
    logic [15:0] temp_word;
    logic        adc_enable;
    logic        commanded_self_test;
    logic        range_from_spi;
    logic [1:0]  range_sel;
    logic        prev_cmd_bad;
    logic        cmd_accepted;
    logic        cmd_rejected;
    int          miscompares = 0;
    int          num_checks  = 0;
    int          n_acc       = 0;
    int          n_rej       = 0;
    logic [4:0]  e_cfg       = 5'h0;

    gsp_port dut (.sys_clk(sys_clk), .rstn(rstn), .mode_sel(mode_sel),
        .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .health_fail(health_fail),
        .rate_word(rate_word), .temp_word(temp_word), .adc_enable(adc_enable),
        .commanded_self_test(commanded_self_test), .range_from_spi(range_from_spi),
        .range_sel(range_sel), .prev_cmd_bad(prev_cmd_bad),
        .cmd_accepted(cmd_accepted), .cmd_rejected(cmd_rejected));

    gsp_host_model host (.sclk(spi_sclk), .ss_n(spi_ss_n), .mosi(spi_mosi),
        .miso(spi_miso), .miso_oe(spi_miso_oe));

    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    // Pulse counters; a stuck pulse shows as an extra count
    always @(posedge sys_clk) begin
        if (cmd_accepted === 1'b1) n_acc++;
        if (cmd_rejected === 1'b1) n_rej++;
    end

    // ------------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------------
    task automatic check_val(input logic [47:0] got, input logic [47:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check_val

    task automatic check_cnt(input int got, input int exp, input string what);
        num_checks++;
        if (got != exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask : check_cnt

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    function automatic logic [7:0] csum8(input logic [39:0] b);
        logic [7:0] s;
        s = b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0];
        return ~s;
    endfunction : csum8

    // ------------------------------------------------------------------
    // One exchange; e_cfg is {self_test, range_src, range_sel, prev_bad}
    // ------------------------------------------------------------------
    task automatic frame(input logic [7:0] cb, input logic [31:0] rsv, input logic bad,
                         input int nbits, input int exp_hits, input string name);
        logic [47:0] cmd;
        logic [47:0] resp;
        logic [7:0]  sb;
        int          hits;
        int          a0;
        int          r0;
        cmd = {cb, rsv, csum8({cb, rsv}) ^ {7'h0, bad}};
        sb  = {health_fail | e_cfg[4], 2'h0, e_cfg[0], e_cfg[4], 3'h1};
        a0  = n_acc;
        r0  = n_rej;
        host.xfer(cmd, nbits, resp, hits);
        repeat (20) @(negedge sys_clk);
        check_val(48'(spi_miso_oe), 48'h0, "oe after frame");
        check_cnt(hits, exp_hits, "oe during frame");
        if (exp_hits > 0 && nbits == 48)
            check_val(resp, {sb, rate_word, temp_word, csum8({sb, rate_word, temp_word})},
                      "status message");
        if (exp_hits > 0 && nbits == 48 && !bad) begin
            e_cfg = {cb[6:3], 1'b0};
            a0++;
        end else if (exp_hits > 0) begin
            e_cfg[0] = 1'b1;
            r0++;
        end
        check_cnt(n_acc, a0, "accepted pulses");
        check_cnt(n_rej, r0, "rejected pulses");
        check_val(48'({commanded_self_test, range_from_spi, range_sel, prev_cmd_bad}),
                  48'(e_cfg), "settings");
        $display("test %s done", name);
    endtask : frame

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        mode_sel = 1'b1;
        health_fail = 1'b0;
        rate_word = 16'h12c0;
        temp_word = 16'h0200;
        repeat (12) @(negedge sys_clk);
        check_val(48'({spi_miso_oe, adc_enable, commanded_self_test, prev_cmd_bad}),
                  48'h0, "reset values");
        rstn = 1'b1;
        repeat (10) @(negedge sys_clk);
        check_val(48'(adc_enable), 48'h1, "converter on");
        frame(8'h30, 32'h0, 1'b0, 48, 48, "range select");
        frame(8'h48, 32'ha5a5_5a5a, 1'b0, 48, 48, "self test");
        rate_word = 16'hf4c0;
        temp_word = 16'h0192;
        frame(8'h38, 32'h0, 1'b1, 48, 48, "bad checksum");
        frame(8'h20, 32'h0, 1'b0, 40, 40, "short frame");
        health_fail = 1'b1;
        frame(8'h18, 32'h0, 1'b0, 48, 48, "health fail");
        health_fail = 1'b0;
        mode_sel = 1'b0;
        repeat (10) @(negedge sys_clk);
        check_val(48'(adc_enable), 48'h0, "converter off");
        frame(8'h40, 32'h0, 1'b0, 16, 0, "mode low");
        mode_sel = 1'b1;
        repeat (10) @(negedge sys_clk);
        frame(8'h00, 32'h0, 1'b0, 48, 48, "back to back a");
        frame(8'h78, 32'hffff_ffff, 1'b0, 48, 48, "back to back b");
        frame(8'h00, 32'h0, 1'b0, 48, 48, "self test shown");
        finish_test;
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        miscompares++;
        $display("MISMATCH at %0t: run did not end", $time);
        finish_test;
    end
endmodule : testbench
